// File: pkg/sbc_pkg.sv
// Package for the standby control block: register map, field layout, reset values.
// Assumes a simple strobe-based register port with read data one cycle after the read strobe.
package sbc_pkg;

  // Register index of the standby control register on the plain port.
  localparam logic [3:0] SBC_STANDBY_CONTROL_ADDR = 4'h0;
  // Register index of the mode status register.
  localparam logic [3:0] SBC_MODE_STATUS_ADDR = 4'h1;

  // Field positions of the standby control register.
  localparam int SBC_STANDBY_SELECT_BIT = 7;
  localparam int SBC_PORT_FLOAT_BIT = 6;
  localparam int SBC_RSVD_ZERO_BIT = 5;
  localparam int SBC_RSVD_ONE_HI = 4;
  localparam int SBC_RSVD_ONE_LO = 1;
  localparam int SBC_IRQ_WAKE_BLOCK_BIT = 0;

  // Reset value: select and float clear, reserved ones set, IRQ wake blocked.
  localparam logic [7:0] SBC_STANDBY_CONTROL_RESET = 8'h1F;
  // Mask of bits that read as fixed ones.
  localparam logic [7:0] SBC_FIXED_ONES = 8'h1E;

  // Power mode state, Gray coded along run, sleep, software standby, hardware standby.
  typedef enum logic [1:0] {
    SBC_RUN = 2'b00,
    SBC_SLEEP = 2'b01,
    SBC_SW_STBY = 2'b11,
    SBC_HW_STBY = 2'b10
  } sbc_mode_t;

  // Wake sources that end sleep or software standby.
  typedef struct packed {
    logic nmi;
    logic [3:0] irq;
    logic other;
  } sbc_wake_t;

endpackage : sbc_pkg

// File: logic/sbc_standby_control.sv
// Standby control register and power mode sequencer of the power-down unit.
// Assumes synchronous inputs on sys_clk_i, pins given active low, one-cycle register strobes.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module sbc_standby_control
  import sbc_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic sys_clk_i, // System clock, 10 MHz.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  input wire logic [ADDR_W-1:0] reg_addr_i, // Register index.
  input wire logic [7:0] reg_wdata_i, // Write data.
  input wire logic reg_wr_i, // Write strobe.
  input wire logic reg_rd_i, // Read strobe.
  output logic [7:0] reg_rdata_o, // Read data, one cycle after the strobe.
  input wire logic watchdog_run_i, // Watchdog run bit from the watchdog.
  input wire logic sleep_exec_i, // Pulse: CPU executed the sleep instruction.
  input wire sbc_wake_t wake_i, // Wake event pulses.
  input wire logic hw_standby_pin_n_i, // Hardware standby request, active low.
  input wire logic poweron_reset_pin_n_i, // Power-on reset pin, active low.
  input wire logic manual_reset_pin_n_i, // Manual reset pin, active low.
  output logic cpu_halt_o, // CPU halted in sleep or standby.
  output logic clock_stop_o, // Clock generator stopped.
  output logic port_hold_o, // I/O ports hold their state.
  output logic port_float_o, // I/O ports in high impedance.
  output logic manual_reset_o // Manual reset request to the CPU.
);

  // Refuses an index width that cannot hold both register indexes or overflows the decode.
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_addr_w_check
    $error("ADDR_W must lie between 1 and 16");
  end

  logic [7:0] ctrl_reg, ctrl_next;
  sbc_mode_t mode_reg, mode_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wr_ctrl;
  logic irq_wake;
  logic por_active;
  // Mode outputs are kept in flops so that no decode glitch reaches the pins.
  logic cpu_halt_reg, cpu_halt_next;
  logic clock_stop_reg, clock_stop_next;
  logic port_hold_reg, port_hold_next;
  logic port_float_reg, port_float_next;

  // Decodes a register index against the given address.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] target);
    hit = (a == ADDR_W'(target));
  endfunction : hit

  // Readback view with reserved bits forced to their constants.
  function automatic logic [7:0] ctrl_view(input logic [7:0] r);
    ctrl_view = (r & ~SBC_FIXED_ONES & ~(8'h01 << SBC_RSVD_ZERO_BIT)) | SBC_FIXED_ONES;
  endfunction : ctrl_view

  assign wr_ctrl = reg_wr_i && hit(reg_addr_i, SBC_STANDBY_CONTROL_ADDR);
  assign por_active = !poweron_reset_pin_n_i;
  assign irq_wake = (|wake_i.irq) && !ctrl_reg[SBC_IRQ_WAKE_BLOCK_BIT];

  // Next value of the standby control register.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (por_active) begin
      ctrl_next = SBC_STANDBY_CONTROL_RESET;
    end else if (wr_ctrl) begin
      ctrl_next[SBC_IRQ_WAKE_BLOCK_BIT] = reg_wdata_i[SBC_IRQ_WAKE_BLOCK_BIT];
      // Clearing is always allowed; setting is refused while the watchdog runs.
      if (!reg_wdata_i[SBC_STANDBY_SELECT_BIT] || !watchdog_run_i) begin
        ctrl_next[SBC_STANDBY_SELECT_BIT] = reg_wdata_i[SBC_STANDBY_SELECT_BIT];
      end
      if (!reg_wdata_i[SBC_PORT_FLOAT_BIT] || !watchdog_run_i) begin
        ctrl_next[SBC_PORT_FLOAT_BIT] = reg_wdata_i[SBC_PORT_FLOAT_BIT];
      end
    end
  end

  // Next power mode.
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      SBC_RUN: begin
        if (sleep_exec_i) begin
          mode_next = ctrl_reg[SBC_STANDBY_SELECT_BIT] ? SBC_SW_STBY : SBC_SLEEP;
        end
      end
      SBC_SLEEP: begin
        if (wake_i.nmi || wake_i.other || (|wake_i.irq) || !manual_reset_pin_n_i) begin
          mode_next = SBC_RUN;
        end
      end
      SBC_SW_STBY: begin
        if (wake_i.nmi || irq_wake || !manual_reset_pin_n_i) begin
          mode_next = SBC_RUN;
        end
      end
      SBC_HW_STBY: begin
        mode_next = SBC_HW_STBY;
      end
    endcase
    if (!hw_standby_pin_n_i) begin
      mode_next = SBC_HW_STBY;
    end else if (por_active) begin
      mode_next = SBC_RUN;
    end else if (mode_reg == SBC_HW_STBY) begin
      mode_next = SBC_RUN;
    end
  end

  // Read data for the cycle after a read strobe.
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd_i) begin
      if (hit(reg_addr_i, SBC_STANDBY_CONTROL_ADDR)) begin
        rdata_next = ctrl_view(ctrl_reg);
      end else if (hit(reg_addr_i, SBC_MODE_STATUS_ADDR)) begin
        rdata_next = {6'h00, mode_reg};
      end
    end
  end

  // Next values of the mode outputs, decoded from the next mode so the flops track the mode register.
  always_comb begin
    cpu_halt_next = (mode_next != SBC_RUN);
    clock_stop_next = (mode_next == SBC_SW_STBY) || (mode_next == SBC_HW_STBY);
    // Port state in standby chosen by the float field; hardware standby always floats.
    port_float_next = (mode_next == SBC_HW_STBY) ||
                      ((mode_next == SBC_SW_STBY) && ctrl_next[SBC_PORT_FLOAT_BIT]);
    port_hold_next = (mode_next == SBC_SW_STBY) && !ctrl_next[SBC_PORT_FLOAT_BIT];
  end

  // Standby control register; reserved positions keep their reset constants for ever.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= SBC_STANDBY_CONTROL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Power mode register.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_reg <= SBC_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Read data register; it holds zero except in the cycle after a read strobe.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Mode output flops; after reset they match the run mode.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cpu_halt_reg <= 1'b0;
      clock_stop_reg <= 1'b0;
      port_hold_reg <= 1'b0;
      port_float_reg <= 1'b0;
    end else begin
      cpu_halt_reg <= cpu_halt_next;
      clock_stop_reg <= clock_stop_next;
      port_hold_reg <= port_hold_next;
      port_float_reg <= port_float_next;
    end
  end

  // Outputs come straight from their flops.
  assign reg_rdata_o = rdata_reg;
  assign cpu_halt_o = cpu_halt_reg;
  assign clock_stop_o = clock_stop_reg;
  assign port_float_o = port_float_reg;
  assign port_hold_o = port_hold_reg;
  // The manual reset request passes straight through so the CPU sees it without delay.
  assign manual_reset_o = !manual_reset_pin_n_i;

  property p_sleep_mode;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (mode_reg == SBC_RUN && sleep_exec_i && !ctrl_reg[SBC_STANDBY_SELECT_BIT] && hw_standby_pin_n_i
       && poweron_reset_pin_n_i) |=> (mode_reg == SBC_SLEEP && !clock_stop_o);
  endproperty
  a_sleep_mode: assert property (p_sleep_mode) else $error("sleep instruction did not enter sleep");

  property p_sw_standby;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (mode_reg == SBC_RUN && sleep_exec_i && ctrl_reg[SBC_STANDBY_SELECT_BIT] && hw_standby_pin_n_i
       && poweron_reset_pin_n_i) |=> (mode_reg == SBC_SW_STBY && clock_stop_o);
  endproperty
  a_sw_standby: assert property (p_sw_standby) else $error("sleep did not enter software standby");

  property p_select_blocked;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (watchdog_run_i && !ctrl_reg[SBC_STANDBY_SELECT_BIT] && !por_active) |=> !ctrl_reg[SBC_STANDBY_SELECT_BIT];
  endproperty
  a_select_blocked: assert property (p_select_blocked) else $error("select set while watchdog ran");

  property p_float_blocked;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (watchdog_run_i && !ctrl_reg[SBC_PORT_FLOAT_BIT]) |=> !ctrl_reg[SBC_PORT_FLOAT_BIT];
  endproperty
  a_float_blocked: assert property (p_float_blocked) else $error("float set while watchdog ran");

  property p_port_state;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (mode_reg == SBC_SW_STBY) |-> (port_float_o == ctrl_reg[SBC_PORT_FLOAT_BIT]) && (port_hold_o != port_float_o);
  endproperty
  a_port_state: assert property (p_port_state) else $error("standby port state wrong");

  property p_reserved_read;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (reg_rd_i && hit(reg_addr_i, SBC_STANDBY_CONTROL_ADDR)) |=> (reg_rdata_o[5:1] == 5'b01111);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits misread");

  property p_irq_blocked;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (mode_reg == SBC_SW_STBY && ctrl_reg[SBC_IRQ_WAKE_BLOCK_BIT] && !wake_i.nmi && manual_reset_pin_n_i
       && hw_standby_pin_n_i && poweron_reset_pin_n_i) |=> (mode_reg == SBC_SW_STBY);
  endproperty
  a_irq_blocked: assert property (p_irq_blocked) else $error("blocked IRQ ended standby");

  property p_irq_wake;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (mode_reg == SBC_SW_STBY && !ctrl_reg[SBC_IRQ_WAKE_BLOCK_BIT] && (|wake_i.irq) && hw_standby_pin_n_i)
      |=> (mode_reg == SBC_RUN);
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("IRQ did not end standby");

  property p_other_fields;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_ctrl && !por_active) |=> (ctrl_reg[SBC_IRQ_WAKE_BLOCK_BIT] == $past(reg_wdata_i[SBC_IRQ_WAKE_BLOCK_BIT]));
  endproperty
  a_other_fields: assert property (p_other_fields) else $error("free field not written");

  property p_hw_standby;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      !hw_standby_pin_n_i |=> (mode_reg == SBC_HW_STBY) && port_float_o;
  endproperty
  a_hw_standby: assert property (p_hw_standby) else $error("hardware standby not entered");

  property p_hw_release;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (mode_reg == SBC_HW_STBY && hw_standby_pin_n_i) |=> (mode_reg == SBC_RUN) && !port_float_o && !cpu_halt_o;
  endproperty
  a_hw_release: assert property (p_hw_release) else $error("hardware standby not left");

  property p_por_reinit;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (por_active && hw_standby_pin_n_i) |=> (ctrl_reg == SBC_STANDBY_CONTROL_RESET) && (mode_reg == SBC_RUN);
  endproperty
  a_por_reinit: assert property (p_por_reinit) else $error("power-on reset pin did not reinitialise");

  property p_rdata_idle;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      !reg_rd_i |=> (reg_rdata_o == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood without a read strobe");

  property p_ctrl_read;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (reg_rd_i && hit(reg_addr_i, SBC_STANDBY_CONTROL_ADDR))
      |=> (reg_rdata_o[SBC_STANDBY_SELECT_BIT] == $past(ctrl_reg[SBC_STANDBY_SELECT_BIT]))
      && (reg_rdata_o[SBC_PORT_FLOAT_BIT] == $past(ctrl_reg[SBC_PORT_FLOAT_BIT]))
      && (reg_rdata_o[SBC_IRQ_WAKE_BLOCK_BIT] == $past(ctrl_reg[SBC_IRQ_WAKE_BLOCK_BIT]));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("writable field misread");

  property p_select_kept;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_ctrl && watchdog_run_i && reg_wdata_i[SBC_STANDBY_SELECT_BIT] && !por_active)
      |=> $stable(ctrl_reg[SBC_STANDBY_SELECT_BIT]);
  endproperty
  a_select_kept: assert property (p_select_kept) else $error("blocked select changed");

  property p_float_kept;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_ctrl && watchdog_run_i && reg_wdata_i[SBC_PORT_FLOAT_BIT] && !por_active)
      |=> $stable(ctrl_reg[SBC_PORT_FLOAT_BIT]);
  endproperty
  a_float_kept: assert property (p_float_kept) else $error("blocked float changed");

  property p_sleep_wake;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (mode_reg == SBC_SLEEP && (|wake_i) && hw_standby_pin_n_i) |=> (mode_reg == SBC_RUN) && !cpu_halt_o;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("wake event did not end sleep");

endmodule : sbc_standby_control

// File: test/sbc_standby_control_tb.sv
// Self-checking testbench for the standby control register and power mode sequencer.
// Assumes the bench drives every input by non-blocking assignment just after the rising clock edge.
`timescale 1ns/1ns
module sbc_standby_control_tb;
  import sbc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic watchdog_run_i = 1'b0;
  logic sleep_exec_i = 1'b0;
  sbc_wake_t wake_i = '0;
  logic hw_n = 1'b1;
  logic por_n = 1'b1;
  logic manual_reset_pin_n = 1'b1;
  logic cpu_halt_o, clock_stop_o, port_hold_o, port_float_o, manual_reset_o;
  logic [7:0] d;
  int n_errors = 0;
  int checked = 0;

  // Clock of 100 ns period.
  always #50 sys_clk_i = ~sys_clk_i;

  sbc_standby_control #(.ADDR_W(4)) sbc_standby_control_inst (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .watchdog_run_i(watchdog_run_i),
    .sleep_exec_i(sleep_exec_i), .wake_i(wake_i), .hw_standby_pin_n_i(hw_n), .poweron_reset_pin_n_i(por_n),
    .manual_reset_pin_n_i(manual_reset_pin_n), .cpu_halt_o(cpu_halt_o), .clock_stop_o(clock_stop_o),
    .port_hold_o(port_hold_o), .port_float_o(port_float_o), .manual_reset_o(manual_reset_o));

  // Prints the verdict and ends the run.
  task automatic end_of_test();
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // Compares a seen value with the expected one and counts the outcome.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One write cycle on the register port.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // One read cycle; the data are taken in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    v = reg_rdata_o;
    @(posedge sys_clk_i);
  endtask : rd

  // One-cycle pulse on the sleep and wake inputs.
  task automatic pulse(input sbc_wake_t w, input logic s);
    wake_i <= w;
    sleep_exec_i <= s;
    @(posedge sys_clk_i);
    wake_i <= '0;
    sleep_exec_i <= 1'b0;
  endtask : pulse

  // Checks halt, clock stop, hold and float in mid-cycle.
  task automatic chk_out(input logic [3:0] exp);
    @(negedge sys_clk_i);
    chk({4'h0, cpu_halt_o, clock_stop_o, port_hold_o, port_float_o}, {4'h0, exp}, "mode outputs");
    @(posedge sys_clk_i);
  endtask : chk_out

  // Cuts a hung run short.
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    n_errors++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(4'h0, d); chk(d, 8'h1F, "control reset");
    rd(4'hF, d); chk(d, 8'h00, "unmapped read");
    // Blocked fields while the watchdog runs; the IRQ field still updates.
    watchdog_run_i <= 1'b1;
    wr(4'h0, 8'hFF); rd(4'h0, d); chk(d, 8'h1F, "blocked set");
    wr(4'h0, 8'hC0); rd(4'h0, d); chk(d, 8'h1E, "blocked partial");
    // Watchdog stopped first, then the fields are set.
    watchdog_run_i <= 1'b0;
    wr(4'h0, 8'hFF); rd(4'h0, d); chk(d, 8'hDF, "all set");
    watchdog_run_i <= 1'b1;
    wr(4'h0, 8'h1E); rd(4'h0, d); chk(d, 8'h1E, "clear while running");
    watchdog_run_i <= 1'b0;
    wr(4'h1, 8'hFF); rd(4'h1, d); chk(d, 8'h00, "status in run");
    // Software standby with held pins, IRQ wake allowed.
    wr(4'h0, 8'h80); pulse(6'h00, 1'b1); chk_out(4'hE);
    rd(4'h1, d); chk(d, 8'h03, "status sw standby");
    pulse(6'h08, 1'b0); chk_out(4'h0);
    // Software standby with floating pins, IRQ wake blocked, NMI wakes.
    wr(4'h0, 8'hC1); pulse(6'h00, 1'b1); chk_out(4'hD);
    pulse(6'h02, 1'b0); chk_out(4'hD);
    pulse(6'h20, 1'b0); chk_out(4'h0);
    // Sleep mode.
    wr(4'h0, 8'h00); pulse(6'h00, 1'b1); chk_out(4'h8);
    rd(4'h1, d); chk(d, 8'h01, "status sleep");
    pulse(6'h01, 1'b0); chk_out(4'h0);
    // Manual reset pin.
    manual_reset_pin_n <= 1'b0;
    @(negedge sys_clk_i);
    chk({7'h00, manual_reset_o}, 8'h01, "manual reset");
    @(posedge sys_clk_i);
    manual_reset_pin_n <= 1'b1;
    // Hardware standby pin.
    hw_n <= 1'b0;
    @(posedge sys_clk_i);
    chk_out(4'hD);
    rd(4'h1, d); chk(d, 8'h02, "status hw standby");
    hw_n <= 1'b1;
    @(posedge sys_clk_i);
    chk_out(4'h0);
    // Power-on reset pin reinitialises the register.
    wr(4'h0, 8'h80);
    por_n <= 1'b0;
    @(posedge sys_clk_i);
    por_n <= 1'b1;
    rd(4'h0, d); chk(d, 8'h1F, "poweron reinit");
    // Mid-run reset out of software standby returns register and mode to their reset values.
    wr(4'h0, 8'hC0); pulse(6'h00, 1'b1); chk_out(4'hD);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    chk_out(4'h0);
    rd(4'h0, d); chk(d, 8'h1F, "mid-run reset");
    end_of_test();
  end
endmodule : sbc_standby_control_tb
